// ### include/timer_pkg.sv
// Constants shared by the auto-reload timer and its helper modules.
package timer_pkg;

  // ----------------------------------------------------------------
  // Register map and page
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h91;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h94;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95;
  localparam logic [3:0] PAGE_TIMER = 4'hF;

  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int BIT_HIGH_FLAG = 7;
  localparam int BIT_LOW_FLAG = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_UNUSED_HI = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_UNUSED_LO = 1;
  localparam int BIT_EXT_CLOCK = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;

  // ----------------------------------------------------------------
  // Count source dividers
  // ----------------------------------------------------------------
  localparam int SYS_DIVIDE = 12;
  localparam int EXT_DIVIDE = 8;
  localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIVIDE - 1);
  localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIVIDE - 1);

  typedef logic [7:0] byte_t;

endpackage : timer_pkg

// ### include/count_if.sv
// Signals between the timer control logic and one 8-bit count stage.
`timescale 1ns/1ps
interface count_if;
  logic count_en;
  logic wrap_reload;
  logic [7:0] reload_val;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] value;
  logic at_max;

  modport stage (
    input count_en, wrap_reload, reload_val, wr_en, wr_data,
    output value, at_max
  );
  modport ctrl (
    output count_en, wrap_reload, reload_val, wr_en, wr_data,
    input value, at_max
  );
endinterface : count_if

// ### verilog/tick_gen.sv
// Count source prescalers: system clock over twelve, external clock over eight.
`timescale 1ns/1ps
module tick_gen
  import timer_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic ext_osc, // External oscillator pin, asynchronous.
  output logic tick_div12, // One-cycle pulse every twelve clocks.
  output logic tick_ext8 // One-cycle pulse every eighth external edge.
);

  logic ext_meta;
  logic ext_sync;
  logic ext_last;
  logic [3:0] sys_cnt;
  logic [2:0] ext_cnt;

  // Two flops before anything looks at the pin; the third only remembers.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_last <= 1'b0;
    end else begin
      ext_meta <= ext_osc;
      ext_sync <= ext_meta;
      ext_last <= ext_sync;
    end
  end

  // Free running divide by twelve of the system clock.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sys_cnt <= 4'h0;
      tick_div12 <= 1'b0;
    end else begin
      tick_div12 <= (sys_cnt == SYS_DIV_LAST);
      sys_cnt <= (sys_cnt == SYS_DIV_LAST) ? 4'h0 : sys_cnt + 4'h1;
    end
  end

  // Divide the synchronised rising edges by eight.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_cnt <= 3'h0;
      tick_ext8 <= 1'b0;
    end else begin
      tick_ext8 <= 1'b0;
      if (ext_sync && !ext_last) begin
        ext_cnt <= ext_cnt + 3'h1;
        tick_ext8 <= (ext_cnt == EXT_DIV_LAST);
      end
    end
  end

endmodule : tick_gen

// ### verilog/byte_counter.sv
// One 8-bit up-counter stage with software load and auto-reload on wrap.
`timescale 1ns/1ps
module byte_counter
  import timer_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  count_if.stage bus // Control and status of this stage.
);

  assign bus.at_max = (bus.value == BYTE_MAX);

  // A software write wins over counting in the same cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus.value <= RESET_BYTE;
    end else if (bus.wr_en) begin
      bus.value <= bus.wr_data;
    end else if (bus.count_en) begin
      if (bus.at_max && bus.wrap_reload) begin
        bus.value <= bus.reload_val;
      end else begin
        bus.value <= bus.value + 8'h01;
      end
    end
  end

endmodule : byte_counter

// ### verilog/reload_timer.sv
// Auto-reload timer, one 16-bit or two 8-bit counters, on the special-function bus.
//
// Behaviour
// - Split clear: one 16-bit up-counter, high and low bytes, wraps FFFF to the reload value.
// - On 16-bit wrap load both reload bytes and set high overflow flag.
// - In 16-bit mode, enabled timer interrupt requests on every 16-bit wrap.
// - In 16-bit mode, low byte interrupt enable adds requests on low byte wraps.
// - Split set: two 8-bit counters, each reloading from its own reload byte.
// - In split mode run control gates only the high counter.
// - Run control set starts the timer, cleared stops it; whole counter in 16-bit.
// - Each byte counts system clock, system clock over 12, or external over 8.
// - The external over-eight source is synchronised to the system clock.
// - In split mode each counter's wrap sets its own overflow flag.
// - Low overflow flag is set on every low byte wrap in either mode.
// - Split mode interrupts on high wraps, plus low wraps when enabled.
// - Hardware never clears the overflow flags; only software writes clear them.
// - High overflow flag set with interrupt enabled requests the service routine.
// - Writing 1 to low byte interrupt enable lets low wraps interrupt.
// - Control bits 4 and 1 read as zero and ignore writes.
// - Count bytes show the 16-bit halves, or each independent 8-bit count.
// - Registers decode at addresses 91h to 95h only on special-function page F.
`timescale 1ns/1ps
module reload_timer (
  input wire logic clk, // System clock, 50 MHz.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic [7:0] sfr_addr, // Special-function address.
  input wire logic [3:0] sfr_page, // Special-function page selector.
  input wire logic sfr_wr, // Write strobe, one cycle.
  input wire logic sfr_rd, // Read strobe, one cycle.
  input wire logic [7:0] sfr_wdata, // Write data.
  output timer_pkg::byte_t sfr_rdata, // Read data, valid the cycle after sfr_rd.
  input wire logic timer_irq_enable, // Timer interrupt enable from the controller.
  input wire logic high_byte_fast_clock_select, // High byte counts system clock in split mode.
  input wire logic low_byte_fast_clock_select, // Low byte counts system clock.
  input wire logic ext_osc, // External oscillator clock pin.
  output logic timer_irq // Interrupt request level.
);
  import timer_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic high_overflow_flag;
  logic low_overflow_flag;
  logic low_byte_irq_enable;
  logic split_mode_select;
  logic run_control;
  logic ext_clock_select;
  byte_t reload_low;
  byte_t reload_high;
  logic page_hit;
  logic wr_control;
  logic wr_reload_low;
  logic wr_reload_high;
  logic wr_count_low;
  logic wr_count_high;
  logic rd_hit;
  logic tick_div12;
  logic tick_ext8;
  logic slow_tick;
  logic tick_low;
  logic tick_high;
  logic wrap_low;
  logic wrap_high;
  byte_t control_view;
  byte_t next_rdata;

  count_if low_if ();
  count_if high_if ();

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Nothing answers off page F, so other pages may reuse these addresses.
  assign page_hit = (sfr_page == PAGE_TIMER);
  assign wr_control = sfr_wr && page_hit && (sfr_addr == ADDR_CONTROL);
  assign wr_reload_low = sfr_wr && page_hit && (sfr_addr == ADDR_RELOAD_LOW);
  assign wr_reload_high = sfr_wr && page_hit && (sfr_addr == ADDR_RELOAD_HIGH);
  assign wr_count_low = sfr_wr && page_hit && (sfr_addr == ADDR_COUNT_LOW);
  assign wr_count_high = sfr_wr && page_hit && (sfr_addr == ADDR_COUNT_HIGH);
  assign rd_hit = sfr_rd && page_hit;

  // ----------------------------------------------------------------
  // Count sources
  // ----------------------------------------------------------------

  // Both prescalers run always, so switching source never restarts a phase.
  tick_gen u_tick_gen (
    .clk(clk),
    .sys_rst(sys_rst),
    .ext_osc(ext_osc),
    .tick_div12(tick_div12),
    .tick_ext8(tick_ext8)
  );

  // Per-byte choice between full rate and the shared slow source.
  assign slow_tick = ext_clock_select ? tick_ext8 : tick_div12;
  assign tick_low = low_byte_fast_clock_select ? 1'b1 : slow_tick;
  assign tick_high = high_byte_fast_clock_select ? 1'b1 : slow_tick;

  // ----------------------------------------------------------------
  // Counter stages
  // ----------------------------------------------------------------

  // The 16-bit counter uses the low byte's source for both halves.
  // The low stage runs free in split mode but obeys run control otherwise.
  assign low_if.count_en = (split_mode_select || run_control) && tick_low;
  // In 16-bit mode the low byte only reloads when the high byte wraps too.
  assign low_if.wrap_reload = split_mode_select || high_if.at_max;
  assign low_if.reload_val = reload_low;
  assign low_if.wr_en = wr_count_low;
  assign low_if.wr_data = sfr_wdata;

  // The high stage counts its own ticks in split mode, low carries otherwise.
  always_comb begin
    if (split_mode_select) begin
      high_if.count_en = run_control && tick_high;
    end else begin
      high_if.count_en = run_control && tick_low && low_if.at_max && !wr_count_low;
    end
  end
  assign high_if.wrap_reload = 1'b1;
  assign high_if.reload_val = reload_high;
  assign high_if.wr_en = wr_count_high;
  assign high_if.wr_data = sfr_wdata;

  byte_counter u_low (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus(low_if.stage)
  );

  byte_counter u_high (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus(high_if.stage)
  );

  // A wrap that a software write overrides is not an overflow.
  assign wrap_low = low_if.count_en && low_if.at_max && !wr_count_low;
  assign wrap_high = high_if.count_en && high_if.at_max && !wr_count_high;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------

  // Configuration bits; bits 4 and 1 are not stored at all.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_byte_irq_enable <= 1'b0;
      split_mode_select <= 1'b0;
      run_control <= 1'b0;
      ext_clock_select <= 1'b0;
    end else if (wr_control) begin
      low_byte_irq_enable <= sfr_wdata[BIT_LOW_IRQ_EN];
      split_mode_select <= sfr_wdata[BIT_SPLIT];
      run_control <= sfr_wdata[BIT_RUN];
      ext_clock_select <= sfr_wdata[BIT_EXT_CLOCK];
    end
  end

  // Overflow flags: hardware only sets, and a set beats a clear written in
  // the same cycle so no wrap is ever lost.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      high_overflow_flag <= 1'b0;
      low_overflow_flag <= 1'b0;
    end else begin
      if (wrap_high) begin
        high_overflow_flag <= 1'b1;
      end else if (wr_control) begin
        high_overflow_flag <= sfr_wdata[BIT_HIGH_FLAG];
      end
      // The 16-bit wrap is also a low byte wrap, so both flags rise together.
      if (wrap_low) begin
        low_overflow_flag <= 1'b1;
      end else if (wr_control) begin
        low_overflow_flag <= sfr_wdata[BIT_LOW_FLAG];
      end
    end
  end

  // Reload bytes, plain storage.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reload_low <= RESET_BYTE;
      reload_high <= RESET_BYTE;
    end else begin
      if (wr_reload_low) begin
        reload_low <= sfr_wdata;
      end
      if (wr_reload_high) begin
        reload_high <= sfr_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------

  // A level: it stays up until software clears the flag, because the flags
  // are the only record of which wrap caused it.
  assign timer_irq = timer_irq_enable &&
    (high_overflow_flag || (low_byte_irq_enable && low_overflow_flag));

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Unused bits are tied low rather than stored.
  always_comb begin
    control_view = RESET_BYTE;
    control_view[BIT_HIGH_FLAG] = high_overflow_flag;
    control_view[BIT_LOW_FLAG] = low_overflow_flag;
    control_view[BIT_LOW_IRQ_EN] = low_byte_irq_enable;
    control_view[BIT_UNUSED_HI] = 1'b0;
    control_view[BIT_SPLIT] = split_mode_select;
    control_view[BIT_RUN] = run_control;
    control_view[BIT_UNUSED_LO] = 1'b0;
    control_view[BIT_EXT_CLOCK] = ext_clock_select;
  end

  // Unmapped addresses and other pages read as zero.
  always_comb begin
    next_rdata = RESET_BYTE;
    case (sfr_addr)
      ADDR_CONTROL: next_rdata = control_view;
      ADDR_RELOAD_LOW: next_rdata = reload_low;
      ADDR_RELOAD_HIGH: next_rdata = reload_high;
      ADDR_COUNT_LOW: next_rdata = low_if.value;
      ADDR_COUNT_HIGH: next_rdata = high_if.value;
      default: next_rdata = RESET_BYTE;
    endcase
  end

  // Read data is captured on the strobe and held until the next read.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata <= RESET_BYTE;
    end else if (sfr_rd) begin
      sfr_rdata <= rd_hit ? next_rdata : RESET_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // A 16-bit wrap with no write in the way.
  sequence s_wrap16;
    !split_mode_select && run_control && tick_low &&
      low_if.at_max && high_if.at_max && !wr_count_low && !wr_count_high;
  endsequence

  // Both bytes and both flags one cycle later.
  sequence s_reloaded16;
    ##1 (low_if.value == $past(reload_low)) && (high_if.value == $past(reload_high)) &&
      high_overflow_flag && low_overflow_flag;
  endsequence

  property p_wrap16;
    s_wrap16 |-> s_reloaded16;
  endproperty
  a_wrap16: assert property (p_wrap16) else $error("16-bit wrap did not reload or flag");

  property p_carry16;
    !split_mode_select && run_control && tick_low && low_if.at_max && !high_if.at_max &&
      !wr_count_low && !wr_count_high |=> (low_if.value == 8'h00) &&
      (high_if.value == $past(high_if.value) + 8'h01);
  endproperty
  a_carry16: assert property (p_carry16) else $error("low byte wrap did not carry");

  property p_low_flag;
    wrap_low |=> low_overflow_flag;
  endproperty
  a_low_flag: assert property (p_low_flag) else $error("low wrap lost its flag");

  property p_split_low;
    split_mode_select && tick_low && low_if.at_max && !wr_count_low
      |=> low_if.value == $past(reload_low);
  endproperty
  a_split_low: assert property (p_split_low) else $error("split low did not reload");

  property p_split_high_hold;
    split_mode_select && !run_control && !wr_count_high |=> $stable(high_if.value);
  endproperty
  a_split_high_hold: assert property (p_split_high_hold) else $error("stopped high byte moved");

  property p_stopped16;
    !split_mode_select && !run_control && !wr_count_low && !wr_count_high
      |=> $stable(low_if.value) && $stable(high_if.value);
  endproperty
  a_stopped16: assert property (p_stopped16) else $error("stopped counter moved");

  property p_fast_high;
    split_mode_select && run_control && high_byte_fast_clock_select &&
      !high_if.at_max && !wr_count_high |=> high_if.value == $past(high_if.value) + 8'h01;
  endproperty
  a_fast_high: assert property (p_fast_high) else $error("fast high byte missed a count");

  property p_div12;
    tick_div12 |=> !tick_div12 [*8] ##1 !tick_div12 [*3] ##1 tick_div12;
  endproperty
  a_div12: assert property (p_div12) else $error("slow tick period is not twelve");

  property p_ext_spacing;
    tick_ext8 |=> !tick_ext8 [*8];
  endproperty
  a_ext_spacing: assert property (p_ext_spacing) else $error("external tick too close");

  property p_flag_sticky;
    high_overflow_flag && !(wr_control && !sfr_wdata[BIT_HIGH_FLAG]) |=> high_overflow_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("high flag fell without a write");

  property p_irq_high;
    timer_irq_enable && high_overflow_flag |-> timer_irq;
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("high flag gave no request");

  property p_irq_low;
    timer_irq_enable && wrap_low && low_byte_irq_enable && !wr_control |=> timer_irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("low wrap gave no request");

  property p_reserved;
    sfr_rd && page_hit && (sfr_addr == ADDR_CONTROL)
      |=> !sfr_rdata[BIT_UNUSED_HI] && !sfr_rdata[BIT_UNUSED_LO];
  endproperty
  a_reserved: assert property (p_reserved) else $error("unused control bit read as one");

  property p_page;
    sfr_wr && !page_hit |=> $stable(reload_low) && $stable(reload_high);
  endproperty
  a_page: assert property (p_page) else $error("write off page took effect");

endmodule : reload_timer

// ### dv/testbench.sv
// Self-checking testbench for the auto-reload timer on the special-function bus.
`timescale 1ns/1ps
module testbench;
  import timer_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus, observation and bookkeeping
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [3:0] sfr_page = 4'h0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  byte_t sfr_rdata;
  logic timer_irq_enable = 1'b0;
  logic high_byte_fast_clock_select = 1'b0;
  logic low_byte_fast_clock_select = 1'b0;
  logic ext_osc = 1'b0;
  logic timer_irq;
  int bad_count = 0;
  int n_checks = 0;
  byte_t rv;

  reload_timer uut (
    .clk(clk),
    .sys_rst(sys_rst),
    .sfr_addr(sfr_addr),
    .sfr_page(sfr_page),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .timer_irq_enable(timer_irq_enable),
    .high_byte_fast_clock_select(high_byte_fast_clock_select),
    .low_byte_fast_clock_select(low_byte_fast_clock_select),
    .ext_osc(ext_osc),
    .timer_irq(timer_irq)
  );

  // The system clock runs at 50 MHz.
  initial begin
    forever #10 clk = ~clk;
  end

  // The oscillator period of 70 ns is 3.5 system clock periods, so its rising edges land 5 ns or 15 ns after a clock edge, in turn.
  initial begin
    forever #35 ext_osc = ~ext_osc;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One write cycle; the strobe drops at the sampling edge, so a following call waits one edge.
  task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data, input logic [3:0] page);
    @(posedge clk);
    sfr_addr <= addr;
    sfr_page <= page;
    sfr_wdata <= data;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] addr, input logic [3:0] page, output byte_t data);
    @(posedge clk);
    sfr_addr <= addr;
    sfr_page <= page;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    data = sfr_rdata;
  endtask : reg_rd

  task automatic expect_reg(input logic [7:0] addr, input logic [7:0] exp, input string what);
    reg_rd(addr, PAGE_TIMER, rv);
    chk(rv, exp, what);
  endtask : expect_reg

  // Flags settle at the edge that ends the last write, so the level is looked at just after it.
  task automatic expect_irq(input logic exp);
    #1;
    chk({7'h00, timer_irq}, {7'h00, exp}, "interrupt request");
  endtask : expect_irq

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_and_decode();
    logic [7:0] addrs [5];
    addrs = '{ADDR_CONTROL, ADDR_RELOAD_LOW, ADDR_RELOAD_HIGH, ADDR_COUNT_LOW, ADDR_COUNT_HIGH};
    foreach (addrs[i]) expect_reg(addrs[i], RESET_BYTE, "reset value");
    reg_wr(ADDR_RELOAD_LOW, 8'hAA, 4'h0);
    expect_reg(ADDR_RELOAD_LOW, 8'h00, "write on other page");
    reg_wr(ADDR_RELOAD_LOW, 8'h5A, PAGE_TIMER);
    expect_reg(ADDR_RELOAD_LOW, 8'h5A, "reload low write");
    reg_rd(ADDR_RELOAD_LOW, 4'h0, rv);
    chk(rv, 8'h00, "read on other page");
    reg_rd(8'h96, PAGE_TIMER, rv);
    chk(rv, 8'h00, "unmapped read");
  endtask : test_reset_and_decode

  // Counting is slow here, so writing all ones cannot wrap a counter before the read.
  task automatic test_unused_bits();
    reg_wr(ADDR_CONTROL, 8'hFF, PAGE_TIMER);
    expect_reg(ADDR_CONTROL, 8'hED, "unused control bits");
    reg_wr(ADDR_CONTROL, 8'h00, PAGE_TIMER);
    expect_reg(ADDR_CONTROL, 8'h00, "control cleared");
  endtask : test_unused_bits

  // Run spans exactly two edges: FFFF wraps to the reload value, then counts once more.
  // The stopping write carries ones in the flag bits, since a zero there would clear them.
  task automatic test_wrap16();
    low_byte_fast_clock_select <= 1'b1;
    timer_irq_enable <= 1'b1;
    reg_wr(ADDR_RELOAD_LOW, 8'h34, PAGE_TIMER);
    reg_wr(ADDR_RELOAD_HIGH, 8'h12, PAGE_TIMER);
    reg_wr(ADDR_COUNT_LOW, 8'hFF, PAGE_TIMER);
    reg_wr(ADDR_COUNT_HIGH, 8'hFF, PAGE_TIMER);
    reg_wr(ADDR_CONTROL, 8'h04, PAGE_TIMER);
    reg_wr(ADDR_CONTROL, 8'hC0, PAGE_TIMER);
    expect_irq(1'b1);
    expect_reg(ADDR_COUNT_LOW, 8'h35, "low after 16-bit wrap");
    expect_reg(ADDR_COUNT_HIGH, 8'h12, "high after 16-bit wrap");
    repeat (20) @(posedge clk);
    expect_reg(ADDR_CONTROL, 8'hC0, "both flags after 16-bit wrap");
    reg_wr(ADDR_CONTROL, 8'h00, PAGE_TIMER);
    expect_irq(1'b0);
  endtask : test_wrap16

  task automatic test_low_wrap16();
    reg_wr(ADDR_COUNT_LOW, 8'hFF, PAGE_TIMER);
    reg_wr(ADDR_COUNT_HIGH, 8'h12, PAGE_TIMER);
    reg_wr(ADDR_CONTROL, 8'h24, PAGE_TIMER);
    reg_wr(ADDR_CONTROL, 8'h60, PAGE_TIMER);
    expect_irq(1'b1);
    expect_reg(ADDR_COUNT_LOW, 8'h01, "low after carry");
    expect_reg(ADDR_COUNT_HIGH, 8'h13, "high after carry");
    expect_reg(ADDR_CONTROL, 8'h60, "low flag only");
    reg_wr(ADDR_CONTROL, 8'h40, PAGE_TIMER);
    expect_irq(1'b0);
    reg_wr(ADDR_CONTROL, 8'h00, PAGE_TIMER);
  endtask : test_low_wrap16

  task automatic test_split();
    high_byte_fast_clock_select <= 1'b1;
    reg_wr(ADDR_RELOAD_LOW, 8'h80, PAGE_TIMER);
    reg_wr(ADDR_RELOAD_HIGH, 8'h55, PAGE_TIMER);
    reg_wr(ADDR_COUNT_LOW, 8'hFF, PAGE_TIMER);
    reg_wr(ADDR_COUNT_HIGH, 8'hFF, PAGE_TIMER);
    reg_wr(ADDR_CONTROL, 8'h08, PAGE_TIMER);
    reg_wr(ADDR_CONTROL, 8'h40, PAGE_TIMER);
    expect_irq(1'b0);
    expect_reg(ADDR_COUNT_LOW, 8'h81, "split low runs without run");
    expect_reg(ADDR_COUNT_HIGH, 8'hFF, "split high held");
    expect_reg(ADDR_CONTROL, 8'h40, "split low flag");
    reg_wr(ADDR_CONTROL, 8'h0C, PAGE_TIMER);
    reg_wr(ADDR_CONTROL, 8'h80, PAGE_TIMER);
    expect_irq(1'b1);
    expect_reg(ADDR_COUNT_LOW, 8'h83, "split low count");
    expect_reg(ADDR_COUNT_HIGH, 8'h56, "split high reload");
    expect_reg(ADDR_CONTROL, 8'h80, "split high flag");
    reg_wr(ADDR_CONTROL, 8'h00, PAGE_TIMER);
    reg_wr(ADDR_COUNT_LOW, 8'hFF, PAGE_TIMER);
    reg_wr(ADDR_CONTROL, 8'h28, PAGE_TIMER);
    reg_wr(ADDR_CONTROL, 8'h60, PAGE_TIMER);
    expect_irq(1'b1);
    expect_reg(ADDR_CONTROL, 8'h60, "split low flag with enable");
    reg_wr(ADDR_CONTROL, 8'h00, PAGE_TIMER);
  endtask : test_split

  // A run of 120 edges holds exactly ten prescaler pulses, whatever the prescaler phase.
  task automatic test_div12();
    low_byte_fast_clock_select <= 1'b0;
    reg_wr(ADDR_COUNT_LOW, 8'h00, PAGE_TIMER);
    reg_wr(ADDR_COUNT_HIGH, 8'h00, PAGE_TIMER);
    reg_wr(ADDR_CONTROL, 8'h04, PAGE_TIMER);
    repeat (118) @(posedge clk);
    reg_wr(ADDR_CONTROL, 8'h00, PAGE_TIMER);
    expect_reg(ADDR_COUNT_LOW, 8'h0A, "divide by twelve count");
  endtask : test_div12

  // The oscillator phase is free, so 160 rising edges may give one tick more or less than 20.
  task automatic test_ext8();
    reg_wr(ADDR_COUNT_LOW, 8'h00, PAGE_TIMER);
    reg_wr(ADDR_CONTROL, 8'h05, PAGE_TIMER);
    repeat (558) @(posedge clk);
    reg_wr(ADDR_CONTROL, 8'h00, PAGE_TIMER);
    reg_rd(ADDR_COUNT_LOW, PAGE_TIMER, rv);
    chk((rv >= 8'h13 && rv <= 8'h15) ? 8'h01 : 8'h00, 8'h01, "external count in range");
  endtask : test_ext8

  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // The scenarios need about 830 cycles; the limit leaves a wide margin.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    test_reset_and_decode();
    test_unused_bits();
    test_wrap16();
    test_low_wrap16();
    test_split();
    test_div12();
    test_ext8();
    final_report();
  end

endmodule : testbench
